// ### crcu_top.sv
/*
 * Checksum unit: 16/32-bit cyclic remainder over bytes written by software,
 * one byte folded per clock.
 * Assumes an Avalon-MM master holding each request until waitrequest is low.
 */
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module crcu_top
    import crcu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire crcu_req_s   bus_req_i,
    output crcu_rsp_s        bus_rsp_o
);

    typedef enum logic [1:0] {
        CRCU_IDLE = 2'b01,
        CRCU_BUSY = 2'b10
    } crcu_state_e;

    crcu_state_e             state;
    crcu_state_e             next_state;
    logic [CTRL_WIDTH-1:0]   ctrl;
    logic [CTRL_WIDTH-1:0]   next_ctrl;
    logic [31:0]             acc;
    logic [31:0]             next_acc;
    logic [31:0]             shreg;
    logic [31:0]             next_shreg;
    logic [2:0]              left;
    logic [2:0]              next_left;
    logic [31:0]             rdata;
    logic [31:0]             next_rdata;
    logic                    wreq;
    logic                    next_wreq;

    logic [1:0]              poly_sel;
    logic [31:0]             poly;
    logic                    is32;
    logic                    req;
    logic                    hit_data;
    logic [31:0]             din;
    logic [31:0]             dproc;
    logic [2:0]              nbytes;
    logic [31:0]             res;
    logic [31:0]             res_proc;
    logic [31:0]             acc_step;

    assign poly_sel = ctrl[CTRL_POLY_LSB +: 2];
    assign is32     = (poly_sel == POLY_E32);
    assign req      = bus_req_i.read | bus_req_i.write;
    assign hit_data = bus_req_i.write && bus_req_i.address == OFS_DATA;

    always_comb begin
        case (poly_sel)
            POLY_CCITT: poly = POLY_CCITT_V;
            POLY_E32:   poly = POLY_E32_V;
            default:    poly = POLY_A16_V;
        endcase
    end

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    // Software-selected byte count of the write; a lane pattern picks the size.
    always_comb begin
        case (bus_req_i.byteenable)
            4'h1:    nbytes = 3'h1;
            4'h3:    nbytes = 3'h2;
            default: nbytes = 3'h4;
        endcase
    end

    // data options; the first byte to fold is placed in the low lane.
    always_comb begin
        din   = bus_req_i.writedata;
        dproc = din;
        if (ctrl[CTRL_DCMPL_BIT]) begin
            dproc = ~dproc;
        end
        if (ctrl[CTRL_DBYTE_BIT]) begin
            case (nbytes)
                3'h2:    dproc = {16'h0000, dproc[7:0], dproc[15:8]};
                3'h4:    dproc = {dproc[7:0], dproc[15:8], dproc[23:16], dproc[31:24]};
                default: dproc = dproc;
            endcase
        end
        if (ctrl[CTRL_DBIT_BIT]) begin
            for (int b = 0; b < 4; b++) begin
                dproc[b*8 +: 8] = rev8(dproc[b*8 +: 8]);
            end
        end
    end

    // one byte folded per clock, MSB first.
    always_comb begin
        logic [7:0] byt;
        logic       fb;
        fb       = 1'b0;
        byt      = shreg[7:0];
        acc_step = acc;
        for (int k = 7; k >= 0; k--) begin
            fb = (is32 ? acc_step[31] : acc_step[15]) ^ byt[k];
            acc_step = {acc_step[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000);
            if (!is32) begin
                acc_step[31:16] = 16'h0000;
            end
        end
    end

    always_comb begin
        res      = is32 ? acc : {16'h0000, acc[15:0]};
        res_proc = res;
        // The whole remainder is mirrored so that the result reads as a reflected checksum.
        if (ctrl[CTRL_SBIT_BIT]) begin
            res_proc = is32 ? {rev8(res_proc[7:0]), rev8(res_proc[15:8]),
                               rev8(res_proc[23:16]), rev8(res_proc[31:24])}
                            : {16'h0000, rev8(res_proc[7:0]), rev8(res_proc[15:8])};
        end
        if (ctrl[CTRL_SBYTE_BIT]) begin
            res_proc = is32 ? {res_proc[7:0], res_proc[15:8], res_proc[23:16], res_proc[31:24]}
                            : {16'h0000, res_proc[7:0], res_proc[15:8]};
        end
        if (ctrl[CTRL_SCMPL_BIT]) begin
            res_proc = is32 ? ~res_proc : {16'h0000, ~res_proc[15:0]};
        end
    end

    // Bus handshake: every access waits one cycle for registered read data;
    // any access, read or write, also waits while a fold is running.
    always_comb begin
        next_state = state;
        next_ctrl  = ctrl;
        next_acc   = acc;
        next_shreg = shreg;
        next_left  = left;
        next_rdata = rdata;
        next_wreq  = 1'b1;
        case (state)
            CRCU_IDLE: begin
                if (req && wreq) begin
                    next_wreq = 1'b0;
                    if (bus_req_i.read) begin
                        case (bus_req_i.address)
                            OFS_CTRL:   next_rdata = {24'h000000, ctrl};
                            OFS_SEED:   next_rdata = acc;
                            OFS_RESULT: next_rdata = res_proc;
                            default:    next_rdata = 32'h0000_0000;
                        endcase
                    end else begin
                        case (bus_req_i.address)
                            OFS_CTRL: next_ctrl = bus_req_i.writedata[CTRL_WIDTH-1:0];
                            OFS_SEED: next_acc = bus_req_i.writedata;
                            default: ;
                        endcase
                        // start of fold, stalls later reads and writes.
                        if (hit_data) begin
                            next_shreg = dproc;
                            next_left  = nbytes;
                            next_state = CRCU_BUSY;
                        end
                    end
                end
            end
            CRCU_BUSY: begin
                // accumulator only changes here or on seed load.
                next_acc   = acc_step;
                next_shreg = {8'h00, shreg[31:8]};
                next_left  = left - BYTES_PER_CYCLE;
                if (left == BYTES_PER_CYCLE) begin
                    next_state = CRCU_IDLE;
                end
            end
            default: next_state = CRCU_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= CRCU_IDLE;
            ctrl  <= CTRL_RESET;
            acc   <= SEED_RESET;
            shreg <= 32'h0000_0000;
            left  <= 3'h0;
            rdata <= 32'h0000_0000;
            wreq  <= 1'b1;
        end else begin
            state <= next_state;
            ctrl  <= next_ctrl;
            acc   <= next_acc;
            shreg <= next_shreg;
            left  <= next_left;
            rdata <= next_rdata;
            wreq  <= next_wreq;
        end
    end

    assign bus_rsp_o.readdata    = rdata;
    assign bus_rsp_o.waitrequest = wreq;

    logic [3:0] busy_cnt;
    logic [3:0] next_busy_cnt;
    always_comb begin
        next_busy_cnt = (state == CRCU_BUSY) ? busy_cnt + 4'h1 : 4'h0;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_cnt <= 4'h0;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end

    word_four_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        busy_cnt <= 4'h4) else $error("fold took more than four cycles");
    byte_one_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state == CRCU_BUSY && left == 3'h1 |=> state == CRCU_IDLE)
        else $error("byte fold not done in one cycle");
    half_two_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state == CRCU_IDLE && hit_data && wreq && nbytes == 3'h2
        |=> state == CRCU_BUSY ##1 state == CRCU_BUSY ##1 state == CRCU_IDLE)
        else $error("half-word fold not done in two cycles");
    busy_stall_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state == CRCU_BUSY |=> wreq) else $error("bus accepted during fold");
    seed_load_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state == CRCU_IDLE && wreq && bus_req_i.write && bus_req_i.address == OFS_SEED
        |=> acc == $past(bus_req_i.writedata)) else $error("seed not loaded");
    acc_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state == CRCU_IDLE && !(bus_req_i.write && wreq && bus_req_i.address == OFS_SEED)
        |=> $stable(acc)) else $error("accumulator changed without cause");
    width16_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !is32 && state == CRCU_BUSY |=> acc[31:16] == 16'h0000)
        else $error("16-bit remainder overflowed");
    word_start_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state == CRCU_IDLE && hit_data && wreq && nbytes == 3'h4 |=> left == 3'h4)
        else $error("word size not taken");

    word_cov: cover property (@(posedge clk_i) state == CRCU_BUSY && left == 3'h4);
    crc32_cov: cover property (@(posedge clk_i) is32 && state == CRCU_BUSY);
    readres_cov: cover property (@(posedge clk_i)
        bus_req_i.read && !wreq && bus_req_i.address == OFS_RESULT);

endmodule

// ### crcu_pkg.sv
/*
 * Shared constants and types for the checksum unit: register offsets,
 * field positions, polynomials, reset values and bus carriers.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package crcu_pkg;

    localparam logic [3:0]  OFS_CTRL   = 4'h0;
    localparam logic [3:0]  OFS_SEED   = 4'h4;
    localparam logic [3:0]  OFS_RESULT = 4'h8;
    localparam logic [3:0]  OFS_DATA   = 4'hC;

    localparam int CTRL_POLY_LSB   = 0;
    localparam int CTRL_DCMPL_BIT  = 2;
    localparam int CTRL_DBYTE_BIT  = 3;
    localparam int CTRL_DBIT_BIT   = 4;
    localparam int CTRL_SCMPL_BIT  = 5;
    localparam int CTRL_SBYTE_BIT  = 6;
    localparam int CTRL_SBIT_BIT   = 7;
    localparam int CTRL_WIDTH      = 8;

    localparam logic [1:0]  POLY_A16   = 2'h0;
    localparam logic [1:0]  POLY_CCITT = 2'h1;
    localparam logic [1:0]  POLY_E32   = 2'h2;

    localparam logic [31:0] POLY_A16_V   = 32'h0000_8005;
    localparam logic [31:0] POLY_CCITT_V = 32'h0000_1021;
    localparam logic [31:0] POLY_E32_V   = 32'h04C1_1DB7;

    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 8'h00;
    localparam logic [31:0]           SEED_RESET = 32'h0000_0000;

    localparam logic [2:0]  BYTES_PER_CYCLE = 3'h1;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } crcu_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } crcu_rsp_s;

endpackage

// ### crcu_top_tb.sv
/*
 * Self-checking testbench for the checksum unit: drives the Avalon-MM
 * port and compares every result with a bench model of the remainder.
 * Assumes crcu_pkg and crcu_top are compiled first.
 */
`timescale 1ns/1ps
module crcu_top_tb
    import crcu_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    crcu_req_s   req = '0;
    crcu_rsp_s   rsp;
    int          failures = 0;
    int          comparisons = 0;
    int          w;
    logic [31:0] rd;
    logic [31:0] macc;
    logic [7:0]  mctrl;

    always #12.5 clk_i = ~clk_i;

    crcu_top crcu_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_req_i(req), .bus_rsp_o(rsp));

    task automatic print_verdict();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_le(input string n, input int e, input int g);
        comparisons++;
        if (g > e) begin
            failures++;
            $display("[FAIL] %s expected <=%0d seen %0d", n, e, g);
        end
    endtask

    // One bus access; the request is held until waitrequest is sampled low.
    task automatic xfer(input logic [3:0] a, input logic r, input logic [31:0] d,
                        input logic [3:0] be);
        @(posedge clk_i);
        req <= '{address: a, read: r, write: !r, byteenable: be, writedata: d};
        w = 0;
        forever begin
            @(posedge clk_i);
            if (rsp.waitrequest === 1'b0) break;
            w++;
            if (w > 50) begin
                failures++;
                $display("[FAIL] waitrequest expected low seen high");
                print_verdict();
            end
        end
        rd = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    function automatic logic [31:0] fold(input logic [31:0] a, input logic [7:0] b);
        logic [31:0] p;
        logic        fb;
        p = (mctrl[1:0] == POLY_E32) ? POLY_E32_V :
            (mctrl[1:0] == POLY_CCITT) ? POLY_CCITT_V : POLY_A16_V;
        for (int i = 0; i < 8; i++) begin
            fb = ((mctrl[1:0] == POLY_E32) ? a[31] : a[15]) ^ b[7-i];
            a = {a[30:0], 1'b0} ^ (fb ? p : 32'h0000_0000);
            if (mctrl[1:0] != POLY_E32) a[31:16] = 16'h0000;
        end
        return a;
    endfunction

    function automatic logic [31:0] post(input logic [31:0] a);
        int s;
        s = (mctrl[1:0] == POLY_E32) ? 0 : 16;
        if (mctrl[CTRL_SCMPL_BIT]) a = ~a;
        if (mctrl[CTRL_SBYTE_BIT]) a = {<<8{a}} >> s;
        if (mctrl[CTRL_SBIT_BIT]) a = {<<{a}} >> s;
        return (s == 0) ? a : {16'h0000, a[15:0]};
    endfunction

    task automatic set_ctrl(input logic [7:0] c, input logic [31:0] s);
        mctrl = c;
        macc = s;
        xfer(OFS_CTRL, 1'b0, {24'h000000, c}, 4'hF);
        xfer(OFS_CTRL, 1'b1, 32'h0000_0000, 4'hF);
        check("ctrl", {24'h000000, c}, rd);
        xfer(OFS_SEED, 1'b0, s, 4'hF);
        xfer(OFS_SEED, 1'b1, 32'h0000_0000, 4'hF);
        check("seed", s, rd);
    endtask

    // Writes data, then reads the result at once so the fold stall is timed.
    task automatic data_wr(input logic [31:0] d, input logic [3:0] be);
        int n;
        n = (be == 4'h1) ? 1 : (be == 4'h3) ? 2 : 4;
        xfer(OFS_DATA, 1'b0, d, be);
        if (mctrl[CTRL_DCMPL_BIT]) d = ~d;
        if (mctrl[CTRL_DBYTE_BIT]) d = {<<8{d}} >> (8 * (4 - n));
        if (mctrl[CTRL_DBIT_BIT]) d = {<<8{{<<{d}}}};
        for (int i = 0; i < n; i++) macc = fold(macc, d[8*i+:8]);
        xfer(OFS_RESULT, 1'b1, 32'h0000_0000, 4'hF);
        check_le("fold wait", n, w);
        check("result", post(macc), rd);
    endtask

    task automatic t_reset();
        xfer(OFS_CTRL, 1'b1, 32'h0000_0000, 4'hF);
        check("ctrl reset", {24'h000000, CTRL_RESET}, rd);
        xfer(OFS_SEED, 1'b1, 32'h0000_0000, 4'hF);
        check("seed reset", SEED_RESET, rd);
        xfer(4'h2, 1'b0, 32'hFFFF_FFFF, 4'hF);
        xfer(4'h2, 1'b1, 32'h0000_0000, 4'hF);
        check("unmapped", 32'h0000_0000, rd);
        mctrl = CTRL_RESET;
        macc = SEED_RESET;
        data_wr(32'h0000_00A5, 4'h1);
    endtask

    task automatic t_polys();
        for (int p = 0; p < 3; p++) begin
            set_ctrl(8'(p), 32'h0000_1D0F);
            data_wr(32'h1234_5678, 4'hF);
            data_wr(32'h0000_BEEF, 4'h3);
            data_wr(32'h0000_0031, 4'h1);
        end
    endtask

    task automatic t_options();
        for (int k = 2; k < 8; k++) begin
            set_ctrl(8'(1 << k) | 8'(k % 3), 32'hFFFF_FFFF >> (k % 3 == 2 ? 0 : 16));
            data_wr(32'hC3A5_0F81, 4'hF);
            data_wr(32'h0000_6E01, 4'h3);
        end
        set_ctrl(8'hFE, 32'hFFFF_FFFF);
        data_wr(32'h8001_7F10, 4'hF);
        set_ctrl(8'h03, 32'h0000_1D0F);
        data_wr(32'h0000_00A5, 4'h1);
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_polys();
        t_options();
        print_verdict();
    end
endmodule
